//--- core/itf_pkg.sv
package itf_pkg;
  // =========================================================
  // register map (word index on the plain register port)
  // =========================================================
  localparam logic [3:0] ITF_REG_CTRL = 4'h0;
  localparam logic [3:0] ITF_REG_CMD = 4'h1;
  localparam logic [3:0] ITF_REG_AMOUNT = 4'h2;
  localparam logic [3:0] ITF_REG_PERIOD = 4'h3;
  localparam logic [3:0] ITF_REG_DECEL = 4'h4;
  localparam logic [3:0] ITF_REG_STATUS0 = 4'h8;

  // =========================================================
  // field positions
  // =========================================================
  localparam int ITF_CTRL_RUN = 0;
  localparam int ITF_CTRL_EDGE = 8;
  localparam int ITF_CTRL_MASK = 16;
  localparam int ITF_CTRL_ORIGIN = 24;
  localparam int ITF_CMD_FEED = 0;
  localparam int ITF_CMD_STOP = 1;
  localparam int ITF_CMD_SEL = 4;
  localparam int ITF_CMD_DIR = 8;
  localparam int ITF_ST_BUSY = 0;
  localparam int ITF_ST_POS = 1;
  localparam int ITF_ST_PROG = 8;
  localparam int ITF_ST_ERR = 9;
  localparam int ITF_ST_INSTR_ERR = 10;

  // =========================================================
  // reset values
  // =========================================================
  localparam logic [31:0] ITF_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ITF_AMOUNT_RST = 32'h0000_0000;
  localparam logic [15:0] ITF_PERIOD_RST = 16'h0064;
  localparam logic [31:0] ITF_DECEL_RST = 32'h0000_0000;

  // =========================================================
  // timing: minimum pulse high time
  // =========================================================
  localparam int ITF_CLK_MHZ = 250;
  localparam int ITF_PULSE_HIGH_NS = 8;
  localparam int ITF_PULSE_HIGH_CYC = (ITF_PULSE_HIGH_NS * ITF_CLK_MHZ + 999) / 1000;

  // channel phases, one-hot
  typedef enum logic [3:0] {
    ITF_IDLE = 4'b0001,
    ITF_SPEED = 4'b0010,
    ITF_FEED = 4'b0100,
    ITF_DECEL = 4'b1000
  } itf_phase_t;
endpackage

//--- core/itf_channel.sv
`timescale 1ns/1ns
// one pulse-output channel with its paired trigger
module itf_channel
  import itf_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic dir_i,
  input wire logic trig_i,
  input wire logic origin_def_i,
  input wire logic [31:0] amount_i,
  input wire logic [15:0] period_i,
  input wire logic [31:0] decel_i,
  output logic pulse_o,
  output logic dir_o,
  output logic busy_o,
  output logic pos_o,
  output logic prog_o,
  output logic err_o,
  output logic signed [31:0] pv_o
);
  itf_phase_t phase_q;
  logic [31:0] remain_q;
  logic [15:0] tick_q;
  logic pulse_q;
  logic prog_q;
  logic err_q;
  logic dir_q;
  logic signed [31:0] pv_q;
  logic step;
  logic ovf;

  // =========================================================
  // pulse timing
  // =========================================================
  assign step = (phase_q != ITF_IDLE) && (tick_q == 16'h0000);
  // position count wraps past signed range
  assign ovf = step && (dir_q ? (pv_q == 32'sh8000_0000) : (pv_q == 32'sh7fff_ffff));

  // period counter, one pulse per period
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || phase_q == ITF_IDLE)
    begin
      tick_q <= 16'h0000;
      pulse_q <= 1'b0;
    end
    else if (step)
    begin
      tick_q <= period_i;
      pulse_q <= 1'b1;
    end
    else
    begin
      tick_q <= tick_q - 16'h0001;
      // pulse held high a few cycles so the drive sees it
      if (period_i - tick_q >= 16'(ITF_PULSE_HIGH_CYC))
      begin
        pulse_q <= 1'b0;
      end
    end
  end

  // =========================================================
  // phase machine: speed, then hardware switch to position
  // =========================================================
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      phase_q <= ITF_IDLE;
      remain_q <= 32'h0000_0000;
      dir_q <= 1'b0;
    end
    else if (stop_i)
    begin
      phase_q <= ITF_IDLE;
    end
    else
    begin
      case (phase_q)
        ITF_IDLE:
        begin
          if (start_i)
          begin
            phase_q <= ITF_SPEED;
            dir_q <= dir_i;
          end
        end
        ITF_SPEED:
        begin
          // trigger edge switches directly, no handler in the path
          if (trig_i)
          begin
            phase_q <= (amount_i <= decel_i) ? ITF_DECEL : ITF_FEED;
            remain_q <= amount_i;
          end
        end
        ITF_FEED:
        begin
          if (step)
          begin
            remain_q <= remain_q - 32'h0000_0001;
            // ramp-down begins when the rest equals the stopping distance
            if (remain_q - 32'h0000_0001 <= decel_i)
            begin
              phase_q <= ITF_DECEL;
            end
          end
        end
        ITF_DECEL:
        begin
          if (remain_q == 32'h0000_0000)
          begin
            phase_q <= ITF_IDLE;
          end
          else if (step)
          begin
            remain_q <= remain_q - 32'h0000_0001;
          end
        end
        default:
        begin
          phase_q <= ITF_IDLE;
        end
      endcase
    end
  end

  // position count, emitted pulses
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      pv_q <= 32'sh0000_0000;
    end
    else if (step && !(phase_q == ITF_DECEL && remain_q == 32'h0000_0000))
    begin
      pv_q <= dir_q ? pv_q - 32'sh0000_0001 : pv_q + 32'sh0000_0001;
    end
  end

  // =========================================================
  // status flags
  // =========================================================
  // in-progress: set on trigger, cleared at stop/end housekeeping
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || stop_i)
    begin
      prog_q <= 1'b0;
    end
    else if (phase_q == ITF_SPEED && trig_i)
    begin
      prog_q <= 1'b1;
    end
    else if (phase_q == ITF_DECEL && remain_q == 32'h0000_0000)
    begin
      prog_q <= 1'b0;
    end
  end

  // error: overflow while feeding with origin defined; set beats clear
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      err_q <= 1'b0;
    end
    else if (origin_def_i && ovf && phase_q != ITF_IDLE && (prog_q || trig_i))
    begin
      err_q <= 1'b1;
    end
    else if (start_i)
    begin
      err_q <= 1'b0;
    end
  end

  assign pulse_o = pulse_q;
  assign dir_o = dir_q;
  assign busy_o = (phase_q != ITF_IDLE);
  assign pos_o = (phase_q == ITF_FEED) || (phase_q == ITF_DECEL);
  assign prog_o = prog_q;
  assign err_o = err_q;
  assign pv_o = pv_q;
endmodule

//--- core/itf_feed.sv
`timescale 1ns/1ns
// What this block does
// - trigger switches speed to counted position stop
// - switch done in hardware, no handler delay
// - selector codes 0..3 pair fixed channel/trigger
// - feed with unmasked trigger gives instruction error
// - triggers share origin/proximity terminals of channels
// - each trigger edge selectable, rising default
// - in-progress bit 8 set on trigger
// - in-progress cleared at start/stop and completion
// - error bit 9 on count overflow, origin defined
// - error cleared at reset and at a new accepted feed
module itf_feed
  import itf_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic trigger_terminal_a0_i,
  input wire logic trigger_terminal_a1_i,
  input wire logic trigger_terminal_b0_i,
  input wire logic trigger_terminal_b1_i,
  output logic [3:0] pulse_o,
  output logic [3:0] dir_o,
  output logic [1:0] origin_in_o,
  output logic [1:0] origin_prox_o
);
  // =========================================================
  // registers
  // =========================================================
  logic [31:0] ctrl_q; // run, edge select, mask, origin defined
  logic [31:0] amount_q; // pulses after trigger
  logic [15:0] period_q; // cycles per pulse, less one
  logic [31:0] decel_q; // pulses needed to ramp down
  logic [3:0] instr_err_q; // rejected feed per channel
  logic [31:0] rdata_q;
  logic [3:0] trig_raw; // terminals routed per channel
  logic [3:0] trig_prev_q;
  logic [3:0] trig_edge;
  logic [3:0] start;
  logic [3:0] stop;
  logic [3:0] busy;
  logic [3:0] pos;
  logic [3:0] prog;
  logic [3:0] err;
  logic [31:0] pv [4];
  logic feed_cmd;
  logic run_chg;
  logic [1:0] sel;

  assign feed_cmd = wr_i && addr_i == ITF_REG_CMD && wdata_i[ITF_CMD_FEED];
  assign sel = wdata_i[ITF_CMD_SEL +: 2];
  // a run bit change is controller start/stop; clears progress flags
  assign run_chg = wr_i && addr_i == ITF_REG_CTRL && wdata_i[ITF_CTRL_RUN] != ctrl_q[ITF_CTRL_RUN];

  // fixed pairings: ch0-trig0, ch1-trig1, ch2-trig4, ch3-trig5
  assign trig_raw = {trigger_terminal_b1_i, trigger_terminal_b0_i,
                     trigger_terminal_a1_i, trigger_terminal_a0_i};
  // the same terminals feed the origin inputs of channels 0 and 2
  assign origin_in_o = {trigger_terminal_b0_i, trigger_terminal_a0_i};
  assign origin_prox_o = {trigger_terminal_b1_i, trigger_terminal_a1_i};

  // edge detect, polarity per trigger
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      // follow the pins in reset so an idle-high terminal gives no false edge
      trig_prev_q <= trig_raw;
    end
    else
    begin
      trig_prev_q <= trig_raw;
    end
  end

  // ctrl edge bit 0 = rising (default), 1 = falling
  assign trig_edge = ~ctrl_q[ITF_CTRL_EDGE +: 4] & trig_raw & ~trig_prev_q
                   | ctrl_q[ITF_CTRL_EDGE +: 4] & ~trig_raw & trig_prev_q;

  // register writes
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_q <= ITF_CTRL_RST;
      amount_q <= ITF_AMOUNT_RST;
      period_q <= ITF_PERIOD_RST;
      decel_q <= ITF_DECEL_RST;
    end
    else if (wr_i)
    begin
      case (addr_i)
        ITF_REG_CTRL: ctrl_q <= wdata_i;
        ITF_REG_AMOUNT: amount_q <= wdata_i;
        ITF_REG_PERIOD: period_q <= wdata_i[15:0];
        ITF_REG_DECEL: decel_q <= wdata_i;
        default: ;
      endcase
    end
  end

  // feed accepted only while the paired trigger is masked
  always_comb
  begin
    start = 4'h0;
    stop = {4{run_chg}};
    if (feed_cmd && ctrl_q[ITF_CTRL_MASK + sel] && !busy[sel])
    begin
      start[sel] = 1'b1;
    end
    if (wr_i && addr_i == ITF_REG_CMD && wdata_i[ITF_CMD_STOP])
    begin
      stop[sel] = 1'b1;
    end
  end

  // instruction error, cleared by the next feed command with the trigger masked on that channel
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      instr_err_q <= 4'h0;
    end
    else if (feed_cmd)
    begin
      instr_err_q[sel] <= ~ctrl_q[ITF_CTRL_MASK + sel];
    end
  end

  // =========================================================
  // channels
  // =========================================================
  for (genvar c = 0; c < 4; c++)
  begin : g_ch
    itf_channel u_ch (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .start_i(start[c]),
      .stop_i(stop[c]),
      .dir_i(wdata_i[ITF_CMD_DIR]),
      .trig_i(trig_edge[c]),
      .origin_def_i(ctrl_q[ITF_CTRL_ORIGIN + c]),
      .amount_i(amount_q),
      .period_i(period_q),
      .decel_i(decel_q),
      .pulse_o(pulse_o[c]),
      .dir_o(dir_o[c]),
      .busy_o(busy[c]),
      .pos_o(pos[c]),
      .prog_o(prog[c]),
      .err_o(err[c]),
      .pv_o(pv[c])
    );
  end

  // =========================================================
  // read port, data one cycle after the strobe
  // =========================================================
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (rd_i)
    begin
      case (addr_i)
        ITF_REG_CTRL: rdata_q <= ctrl_q;
        ITF_REG_AMOUNT: rdata_q <= amount_q;
        ITF_REG_PERIOD: rdata_q <= {16'h0000, period_q};
        ITF_REG_DECEL: rdata_q <= decel_q;
        4'h8, 4'h9, 4'ha, 4'hb:
        begin
          rdata_q <= 32'h0000_0000;
          rdata_q[ITF_ST_BUSY] <= busy[addr_i[1:0]];
          rdata_q[ITF_ST_POS] <= pos[addr_i[1:0]];
          rdata_q[ITF_ST_PROG] <= prog[addr_i[1:0]];
          rdata_q[ITF_ST_ERR] <= err[addr_i[1:0]];
          rdata_q[ITF_ST_INSTR_ERR] <= instr_err_q[addr_i[1:0]];
        end
        4'hc, 4'hd, 4'he, 4'hf: rdata_q <= pv[addr_i[1:0]];
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
    else
    begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign rdata_o = rdata_q;
endmodule

//--- dv/itf_feed_sva.sv
`timescale 1ns/1ns
// ====
// port checker for the trigger feed block
module itf_feed_sva
  import itf_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic trigger_terminal_a0_i,
  input wire logic trigger_terminal_a1_i,
  input wire logic trigger_terminal_b0_i,
  input wire logic trigger_terminal_b1_i,
  input wire logic [3:0] pulse_o,
  input wire logic [3:0] dir_o,
  input wire logic [1:0] origin_in_o,
  input wire logic [1:0] origin_prox_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [31:0] ctrl_q; // control word as last written
  logic [3:0] rej_q; // refused feed not yet overwritten
  logic ctl_wr; // control word written
  logic cmd_wr; // command word written
  logic [1:0] sel; // channel code of the command
  logic [1:0] org_t; // terminals shared with origin inputs
  logic [1:0] prox_t; // terminals shared with proximity inputs
  assign ctl_wr = wr_i && addr_i == ITF_REG_CTRL;
  assign cmd_wr = wr_i && addr_i == ITF_REG_CMD;
  assign sel = wdata_i[5:4];
  assign org_t = {trigger_terminal_b0_i, trigger_terminal_a0_i};
  assign prox_t = {trigger_terminal_b1_i, trigger_terminal_a1_i};
  // control shadow
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      ctrl_q <= ITF_CTRL_RST;
    else if (ctl_wr)
      ctrl_q <= wdata_i;
  end
  // a control write or a later command on that channel forgets a refusal: the flag's clearing points are loose
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i || ctl_wr)
      rej_q <= 4'h0;
    else if (cmd_wr)
      rej_q[sel] <= wdata_i[ITF_CMD_FEED] && !ctrl_q[ITF_CTRL_MASK + sel];
  end
  // ====
  // assertions
  rd_quiet_a: assert property (!rd_i |=> rdata_o == 32'h0000_0000)
    else $error("read data not zero outside a read");
  unmapped_a: assert property (rd_i && addr_i inside {4'h5, 4'h6, 4'h7} |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  origin_pass_a: assert property (
    ($stable(org_t) && $past(rst_n_i)) [*2] |-> origin_in_o == org_t)
    else $error("origin terminal not shared");
  prox_pass_a: assert property (
    ($stable(prox_t) && $past(rst_n_i)) [*2] |-> origin_prox_o == prox_t)
    else $error("proximity terminal not shared");
  pulse_width_a: assert property (
    $rose(pulse_o[0]) |-> pulse_o[0] [*2])
    else $error("pulse high too short");
  stop_all_a: assert property (
    ctl_wr && wdata_i[0] != ctrl_q[0] |-> ##3 (pulse_o == 4'h0) [*8])
    else $error("pulses after start or stop");
  refuse_flag_a: assert property (
    rd_i && addr_i[3:2] == 2'b10 && rej_q[addr_i[1:0]] |=> rdata_o[ITF_ST_INSTR_ERR])
    else $error("refused feed without instruction error");
  dir_hold_a: assert property (
    pulse_o[2] && $past(pulse_o[2]) |-> $stable(dir_o[2]))
    else $error("direction moved during a pulse");
  feed_c: cover property (cmd_wr && wdata_i[0] && ctrl_q[ITF_CTRL_MASK + sel]);
  refuse_c: cover property (rej_q != 4'h0);
  stop_c: cover property (ctl_wr && wdata_i[0] != ctrl_q[0]);
endmodule

bind itf_feed itf_feed_sva i_sva (.core_clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
  .rdata_o, .trigger_terminal_a0_i, .trigger_terminal_a1_i, .trigger_terminal_b0_i,
  .trigger_terminal_b1_i, .pulse_o, .dir_o, .origin_in_o, .origin_prox_o);

//--- dv/itf_drive_model.sv
`timescale 1ns/1ns
// ====
// motor drive counting pulses, with one marker sensor per channel
module itf_drive_model
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] pulse_i,
  input wire logic [3:0] arm_i,
  input wire logic [3:0] idle_i,
  output logic [3:0] trig_o = 4'h0,
  output logic [3:0][7:0] tot_o,
  output logic [3:0][7:0] after_o
);
  logic [3:0] prev_q; // pulse levels one cycle ago
  logic [3:0][7:0] since_q; // pulses since the sensor was armed
  // the marker passes after three pulses of the speed run
  always @(posedge core_clk_i)
  begin
    prev_q <= pulse_i;
    for (int k = 0; k < 4; k++)
    begin
      if (!rst_n_i)
        tot_o[k] <= 8'h00;
      else if (pulse_i[k] && !prev_q[k])
        tot_o[k] <= tot_o[k] + 8'h01;
      if (!arm_i[k])
        since_q[k] <= 8'h00;
      else if (pulse_i[k] && !prev_q[k])
        since_q[k] <= since_q[k] + 8'h01;
      // a falling-edge sensor idles high and drops on the marker
      trig_o[k] <= idle_i[k] ^ (arm_i[k] && since_q[k] >= 8'h03);
      if (!arm_i[k])
        after_o[k] <= 8'h00;
      else if (pulse_i[k] && !prev_q[k] && since_q[k] >= 8'h03)
        after_o[k] <= after_o[k] + 8'h01;
    end
  end
endmodule

//--- dv/itf_feed_tb_top.sv
`timescale 1ns/1ns
// ====
// self-checking bench for the trigger feed block
module itf_feed_tb_top
  import itf_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
  logic [3:0] addr = 4'h0, trig, pulse, dir, arm = 4'h0, idle = 4'h0;
  logic [31:0] wdata = 32'h0000_0000, rdata, base, rnd = 32'h0000_0006;
  logic [3:0][7:0] tot, aft; // pulse counts seen by the drive
  logic [1:0] org, prox;
  logic [7:0] amt;
  logic [31:0] exp_q[$], msk_q[$]; // pending read expectations
  int bad_count = 0, comparisons = 0;
  always #2 core_clk = ~core_clk;
  itf_feed i_dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .trigger_terminal_a0_i(trig[0]),
    .trigger_terminal_a1_i(trig[1]), .trigger_terminal_b0_i(trig[2]),
    .trigger_terminal_b1_i(trig[3]), .pulse_o(pulse), .dir_o(dir), .origin_in_o(org),
    .origin_prox_o(prox));
  itf_drive_model i_drv (.core_clk_i(core_clk), .rst_n_i(rst_n), .pulse_i(pulse),
    .arm_i(arm), .idle_i(idle), .trig_o(trig), .tot_o(tot), .after_o(aft));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // ====
  // register port; a spare cycle after each strobe keeps drives apart
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(posedge core_clk);
  endtask
  // read data stands only in the cycle after the strobe
  always @(posedge core_clk)
  begin
    rd_q <= rd;
    if (rd_q)
      chk("rdata", rdata & msk_q.pop_front(), exp_q.pop_front());
  end
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge core_clk);
    bad_count++;
    test_done;
  end
  // ====
  // main sequence
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rreg(ITF_REG_CTRL, 32'h0000_0000, 32'hffff_ffff);
    rreg(ITF_REG_PERIOD, 32'h0000_0064, 32'h0000_ffff);
    rreg(4'h6, 32'h0000_0000, 32'hffff_ffff);
    for (int k = 0; k < 4; k++)
      rreg(ITF_REG_STATUS0 | 4'(k), 32'h0000_0000, 32'h0000_0703);
    wreg(ITF_REG_PERIOD, 32'h0000_0009);
    wreg(ITF_REG_DECEL, 32'h0000_0002);
    wreg(ITF_REG_CTRL, 32'h0f0f_0001);
    repeat (12) @(posedge core_clk);
    // every channel code, odd channels on a falling marker edge
    // no origin search is ever run on channels 0 and 2 here
    for (int k = 0; k < 4; k++)
    begin
      rnd = xs(rnd);
      amt = 8'h04 + {5'h00, rnd[2:0]};
      idle[k] <= k[0];
      wreg(ITF_REG_CTRL, 32'h0f0f_0001 | 32'h0000_0a00);
      wreg(ITF_REG_AMOUNT, {24'h00_0000, amt});
      base = tot;
      wreg(ITF_REG_CMD, {23'h00_0000, rnd[4], 2'b00, 2'(k), 4'h1});
      rreg(ITF_REG_STATUS0 | 4'(k), 32'h0000_0001, 32'h0000_0703);
      arm[k] <= 1'b1;
      repeat (45) @(posedge core_clk);
      rreg(ITF_REG_STATUS0 | 4'(k), 32'h0000_0103, 32'h0000_0103);
      repeat (12 * amt + 40) @(posedge core_clk);
      chk("fed pulses", 32'(aft[k]), 32'(amt));
      chk("direction", 32'(dir[k]), 32'(rnd[4]));
      for (int j = 0; j < 4; j++)
        if (j != k)
          chk("other channel", 32'(tot[j]), 32'(base[8*j+:8]));
      // position count: every pulse the drive saw, signed by direction
      rreg(4'hc | 4'(k), rnd[4] ? -32'(tot[k]) : 32'(tot[k]), 32'hffff_ffff);
      rreg(ITF_REG_STATUS0 | 4'(k), 32'h0000_0000, 32'h0000_0101);
      arm[k] <= 1'b0;
    end
    // unmasked triggers: every feed is refused
    wreg(ITF_REG_CTRL, 32'h0f00_0a01);
    base = tot;
    for (int k = 0; k < 4; k++)
    begin
      wreg(ITF_REG_CMD, {26'h000_0000, 2'(k), 4'h1});
      rreg(ITF_REG_STATUS0 | 4'(k), 32'h0000_0400, 32'h0000_0401);
    end
    chk("refused pulses", tot, base);
    // stop in mid-feed drops the in-progress flag
    wreg(ITF_REG_CTRL, 32'h0f0f_0a01);
    wreg(ITF_REG_AMOUNT, 32'h0000_00ff);
    wreg(ITF_REG_CMD, 32'h0000_0001);
    arm[0] <= 1'b1;
    repeat (45) @(posedge core_clk);
    rreg(ITF_REG_STATUS0, 32'h0000_0101, 32'h0000_0501);
    wreg(ITF_REG_CTRL, 32'h0f0f_0a00);
    rreg(ITF_REG_STATUS0, 32'h0000_0000, 32'h0000_0101);
    arm[0] <= 1'b0;
    // restart, then the stop command ends a feed on channel 2
    wreg(ITF_REG_CTRL, 32'h0f0f_0a01);
    repeat (12) @(posedge core_clk);
    wreg(ITF_REG_CMD, 32'h0000_0021);
    arm[2] <= 1'b1;
    repeat (45) @(posedge core_clk);
    rreg(ITF_REG_STATUS0 | 4'h2, 32'h0000_0103, 32'h0000_0103);
    chk("shared terminals", 32'({prox, org}), 32'h0000_000e);
    wreg(ITF_REG_CMD, 32'h0000_0022);
    rreg(ITF_REG_STATUS0 | 4'h2, 32'h0000_0000, 32'h0000_0103);
    arm[2] <= 1'b0;
    repeat (4) @(posedge core_clk);
    test_done;
  end
endmodule
